// *** design/uart_break_baud.sv ***
// Serial port core: noise filter, break field send and receive, baud generator
//
// Contract
// R1 - Sample receive pin each base clock; filtered level changes on two agreeing samples.
// R2 - Internal receive processing lags the pin by two base clocks.
// R3 - With power bit set the transmit pin idles high.
// R4 - Power and transmit enable set: break trigger bit starts a break field.
// R5 - Break field holds transmit low for 13 to 20 bit times per length field.
// R6 - Length code 101 gives 13 bits, each step adds one, 100 gives 20.
// R7 - Break end raises transmit complete, clears the trigger, resumes normal mode.
// R8 - After a break, transmit stays idle until new data or a new trigger.
// R9 - Power, receive enable and break receive trigger arm break reception.
// R10 - Armed break reception detects start and shifts data as normal reception.
// R11 - Falling edge: count divisor, resample; low there is a valid start bit.
// R12 - Break of 11 bits or more: complete interrupt, clear break flag and trigger.
// R13 - During break reception overrun, parity and framing errors are suppressed.
// R14 - During break reception the receive buffer is not written.
// R15 - Break of 10 bits or less: no interrupt, bits stay set, mode stays.
// R16 - Base clock reaches the logic only with power set, else held low.
// R17 - Separate 8-bit divider counters for transmit and receive on the base clock.
// R18 - Transmit counter held at zero unless power and transmit enable are set.
// R19 - Transmit counter clears at first write and per frame when more data follows.
// R20 - Receive counter held zero when disabled; runs from start bit to frame end.
// R21 - Bit rate is base clock over twice divisor, divisor 4 to 255.
// R22 - Select codes 0 to 10 pick clock over 2 to the code; 11 picks timer.
// R23 - Software starts the timer before selecting it, with 50 percent duty.
`timescale 1ns/1ps
`default_nettype none

module uart_break_baud #(
  parameter int PRE_BITS = uart_brk_pkg::PRE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Software control
  input wire uart_brk_pkg::serial_ctrl_s ctrl,
  input wire logic break_tx_set,
  input wire logic break_rx_set,
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic rx_buffer_read,
  input wire logic rx_status_read,
  // Pins
  input wire logic serial_rx_pin,
  input wire logic timer_output_pin,
  output logic serial_tx_pin,
  // Status
  output logic break_tx_trigger,
  output logic break_rx_trigger,
  output logic break_rx_flag,
  output logic tx_busy,
  output logic tx_buffer_full,
  output logic [7:0] rx_buffer,
  output logic [2:0] rx_error_status,
  // Interrupt requests
  output logic tx_complete_irq,
  output logic rx_complete_irq,
  output logic rx_error_irq
);

  // Prescaler must cover the largest power-of-two select code
  if (PRE_BITS < 10) begin : g_pre_check
    $error("PRE_BITS too small for select code range");
  end

  // Divisors below the legal minimum run at the minimum
  function automatic logic [7:0] eff_div(input logic [7:0] d);
    eff_div = (d < uart_brk_pkg::DIV_MIN) ? uart_brk_pkg::DIV_MIN : d;
  endfunction : eff_div

  // Half-bit wrap of a divider counter
  function automatic logic at_wrap(input logic [7:0] cnt, input logic [7:0] k);
    at_wrap = (cnt == 8'(k - 8'h01));
  endfunction : at_wrap

  // Break length code to bit times
  function automatic logic [4:0] brk_bits(input logic [2:0] code);
    brk_bits = uart_brk_pkg::BRK_BASE_BITS + {2'h0, 3'(code - uart_brk_pkg::BRK_BASE_CODE)};
  endfunction : brk_bits

  logic powered;
  logic tx_run;
  logic rx_run;
  logic [7:0] div_k;
  assign powered = ctrl.port_power_bit;
  assign tx_run = powered & ctrl.tx_enable_bit;
  assign rx_run = powered & ctrl.rx_enable_bit;
  assign div_k = eff_div(ctrl.divisor_field);

  // Pin synchronisers
  logic rx_meta_reg, rx_sync_reg;
  logic tmr_meta_reg, tmr_sync_reg, tmr_prev_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      tmr_meta_reg <= 1'b0;
      tmr_sync_reg <= 1'b0;
      tmr_prev_reg <= 1'b0;
    end else begin
      rx_meta_reg <= serial_rx_pin;
      rx_sync_reg <= rx_meta_reg;
      tmr_meta_reg <= timer_output_pin;
      tmr_sync_reg <= tmr_meta_reg;
      tmr_prev_reg <= tmr_sync_reg;
    end
  end

  // Prescaler, stopped and cleared while unpowered
  logic [PRE_BITS-1:0] pre_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !powered) begin // R16
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // Base clock enable from the selector
  logic base_tick;
  logic [PRE_BITS-1:0] pre_mask;
  always_comb begin
    pre_mask = ~({PRE_BITS{1'b1}} << ctrl.clock_select_field);
    if (!powered) begin
      base_tick = 1'b0; // R16
    end else if (ctrl.clock_select_field == uart_brk_pkg::CS_TIMER) begin
      base_tick = tmr_sync_reg & ~tmr_prev_reg; // R22
    end else if (ctrl.clock_select_field <= uart_brk_pkg::CS_MAX_DIV) begin
      base_tick = ((pre_reg & pre_mask) == pre_mask); // R22
    end else begin
      base_tick = 1'b0;
    end
  end

  // Receive noise filter: two agreeing base clock samples
  logic flt_s1_reg, rx_filt_reg, rx_filt_prev_reg;
  logic rx_fall;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      flt_s1_reg <= 1'b1;
      rx_filt_reg <= 1'b1;
      rx_filt_prev_reg <= 1'b1;
    end else begin
      rx_filt_prev_reg <= rx_filt_reg;
      if (base_tick) begin
        flt_s1_reg <= rx_sync_reg; // R1
        if (rx_sync_reg == flt_s1_reg) begin
          rx_filt_reg <= rx_sync_reg; // R2
        end
      end
    end
  end
  assign rx_fall = rx_filt_prev_reg & ~rx_filt_reg;

  // Transmit side signals
  uart_brk_pkg::tx_state_e tx_st_reg;
  logic [7:0] tx_cnt_reg;
  logic tx_half_reg;
  logic [4:0] tx_bits_reg;
  logic [9:0] tx_shift_reg;
  logic [7:0] tx_buffer_reg;
  logic tx_buf_full_reg;
  logic break_tx_trigger_reg;
  logic tx_bit_end, tx_start_frame, tx_start_brk, tx_frame_end, tx_brk_end;
  assign tx_bit_end = base_tick & at_wrap(tx_cnt_reg, div_k) & tx_half_reg; // R21
  assign tx_start_frame = (tx_st_reg == uart_brk_pkg::TX_IDLE) & tx_buf_full_reg;
  assign tx_start_brk = (tx_st_reg == uart_brk_pkg::TX_IDLE) & ~tx_buf_full_reg
    & break_tx_trigger_reg; // R8
  assign tx_frame_end = (tx_st_reg == uart_brk_pkg::TX_FRAME) & tx_bit_end
    & (tx_bits_reg == uart_brk_pkg::TX_FRAME_LAST);
  assign tx_brk_end = (tx_st_reg == uart_brk_pkg::TX_BREAK) & tx_bit_end
    & (tx_bits_reg == 5'(brk_bits(ctrl.break_length_field) - 5'h01)); // R6

  // Transmit divider counter
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !tx_run) begin // R18
      tx_cnt_reg <= 8'h00;
      tx_half_reg <= 1'b0;
    end else if (tx_start_frame || tx_start_brk) begin // R19
      tx_cnt_reg <= 8'h00;
      tx_half_reg <= 1'b0;
    end else if (base_tick) begin // R17
      if (at_wrap(tx_cnt_reg, div_k)) begin
        tx_cnt_reg <= 8'h00;
        tx_half_reg <= ~tx_half_reg;
      end else begin
        tx_cnt_reg <= tx_cnt_reg + 8'h01;
      end
    end
  end

  // Transmit buffer, one byte pending
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !tx_run) begin
      tx_buffer_reg <= 8'h00;
      tx_buf_full_reg <= 1'b0;
    end else if (tx_write && !tx_buf_full_reg) begin
      tx_buffer_reg <= tx_data;
      tx_buf_full_reg <= 1'b1;
    end else if (tx_start_frame) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  // Break transmit trigger, set wins over the hardware clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      break_tx_trigger_reg <= 1'b0;
    end else if (break_tx_set && tx_run) begin // R4
      break_tx_trigger_reg <= 1'b1;
    end else if (tx_brk_end) begin
      break_tx_trigger_reg <= 1'b0; // R7
    end
  end

  // Transmit sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !tx_run) begin
      tx_st_reg <= uart_brk_pkg::TX_IDLE;
      tx_bits_reg <= 5'h00;
      tx_shift_reg <= uart_brk_pkg::TX_IDLE_SHIFT;
    end else begin
      case (tx_st_reg)
        uart_brk_pkg::TX_IDLE: begin
          tx_bits_reg <= 5'h00;
          if (tx_start_frame) begin
            tx_shift_reg <= {1'b1, tx_buffer_reg, 1'b0};
            tx_st_reg <= uart_brk_pkg::TX_FRAME;
          end else if (tx_start_brk) begin
            tx_st_reg <= uart_brk_pkg::TX_BREAK; // R4
          end
        end
        uart_brk_pkg::TX_FRAME: begin
          if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_bits_reg <= tx_bits_reg + 5'h01;
          end
          if (tx_frame_end) begin
            tx_st_reg <= uart_brk_pkg::TX_IDLE;
          end
        end
        uart_brk_pkg::TX_BREAK: begin
          if (tx_bit_end) begin
            tx_bits_reg <= tx_bits_reg + 5'h01; // R5
          end
          if (tx_brk_end) begin
            tx_st_reg <= uart_brk_pkg::TX_IDLE; // R7
          end
        end
        default: begin
          tx_st_reg <= uart_brk_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Transmit pin, busy flag and completion pulse; pin goes high on the clock after disable
  logic serial_tx_reg, tx_complete_irq_reg, tx_busy_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      serial_tx_reg <= 1'b1;
      tx_complete_irq_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
    end else begin
      tx_complete_irq_reg <= tx_frame_end | tx_brk_end; // R7
      tx_busy_reg <= tx_run & (tx_start_frame | tx_start_brk
        | (tx_busy_reg & ~tx_frame_end & ~tx_brk_end));
      if (tx_run && tx_st_reg == uart_brk_pkg::TX_FRAME) begin
        serial_tx_reg <= tx_shift_reg[0];
      end else if (tx_run && tx_st_reg == uart_brk_pkg::TX_BREAK) begin
        serial_tx_reg <= 1'b0; // R5
      end else begin
        serial_tx_reg <= 1'b1; // R3
      end
    end
  end

  // Receive side signals
  uart_brk_pkg::rx_state_e rx_st_reg;
  logic [7:0] rx_cnt_reg;
  logic rx_half_reg;
  logic [3:0] rx_bits_reg;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_low_reg;
  logic break_rx_trigger_reg, break_rx_flag_reg;
  logic rx_buf_full_reg;
  logic rx_sample, rx_stop, rx_brk_ok, rx_ove, rx_fe;
  assign rx_sample = base_tick & at_wrap(rx_cnt_reg, div_k) & ~rx_half_reg;
  assign rx_stop = (rx_st_reg == uart_brk_pkg::RX_BITS) & rx_sample
    & (break_rx_trigger_reg ? rx_filt_reg : (rx_bits_reg == uart_brk_pkg::RX_STOP_IDX));
  assign rx_brk_ok = rx_stop & break_rx_trigger_reg
    & (rx_low_reg >= uart_brk_pkg::BRK_RX_MIN); // R12 R15
  assign rx_ove = rx_buf_full_reg;
  assign rx_fe = ~rx_filt_reg;

  // Receive divider counter, idle between frames
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !rx_run || rx_st_reg == uart_brk_pkg::RX_IDLE) begin // R20
      rx_cnt_reg <= 8'h00;
      rx_half_reg <= 1'b0;
    end else if (base_tick) begin // R17
      if (at_wrap(rx_cnt_reg, div_k)) begin
        rx_cnt_reg <= 8'h00;
        rx_half_reg <= ~rx_half_reg;
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 8'h01;
      end
    end
  end

  // Receive sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !rx_run) begin
      rx_st_reg <= uart_brk_pkg::RX_IDLE;
      rx_bits_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_low_reg <= 8'h00;
    end else begin
      case (rx_st_reg)
        uart_brk_pkg::RX_IDLE: begin
          rx_bits_reg <= 4'h0;
          if (rx_fall) begin
            rx_st_reg <= uart_brk_pkg::RX_START; // R11
          end
        end
        uart_brk_pkg::RX_START: begin
          if (rx_sample) begin
            rx_low_reg <= 8'h01;
            rx_st_reg <= rx_filt_reg ? uart_brk_pkg::RX_IDLE : uart_brk_pkg::RX_BITS; // R11
          end
        end
        uart_brk_pkg::RX_BITS: begin
          if (rx_stop) begin
            rx_st_reg <= uart_brk_pkg::RX_IDLE; // R15
          end else if (rx_sample) begin
            rx_shift_reg <= {rx_filt_reg, rx_shift_reg[7:1]}; // R10
            rx_bits_reg <= rx_bits_reg + 4'h1;
            if (!rx_filt_reg && rx_low_reg != uart_brk_pkg::BRK_LOW_MAX) begin
              rx_low_reg <= rx_low_reg + 8'h01;
            end
          end
        end
        default: begin
          rx_st_reg <= uart_brk_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Break receive trigger and flag, set wins over the hardware clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      break_rx_trigger_reg <= 1'b0;
      break_rx_flag_reg <= 1'b0;
    end else begin
      if (break_rx_set && rx_run) begin // R9
        break_rx_trigger_reg <= 1'b1;
      end else if (rx_brk_ok) begin
        break_rx_trigger_reg <= 1'b0; // R12
      end
      if (rx_st_reg == uart_brk_pkg::RX_START && rx_sample && !rx_filt_reg
          && break_rx_trigger_reg) begin
        break_rx_flag_reg <= 1'b1;
      end else if (rx_brk_ok) begin
        break_rx_flag_reg <= 1'b0; // R12
      end
    end
  end

  // Receive buffer, errors and completion pulses
  logic [7:0] rx_buffer_reg;
  logic [2:0] rx_err_reg;
  logic rx_complete_irq_reg, rx_error_irq_reg;
  logic normal_stop;
  assign normal_stop = rx_stop & ~break_rx_trigger_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_buffer_reg <= uart_brk_pkg::RXB_RESET;
      rx_buf_full_reg <= 1'b0;
      rx_err_reg <= 3'h0;
      rx_complete_irq_reg <= 1'b0;
      rx_error_irq_reg <= 1'b0;
    end else begin
      rx_complete_irq_reg <= normal_stop | rx_brk_ok; // R12
      rx_error_irq_reg <= normal_stop & (rx_ove | rx_fe); // R13
      if (normal_stop && !rx_ove) begin // R14
        rx_buffer_reg <= rx_shift_reg;
        rx_buf_full_reg <= 1'b1;
      end else if (rx_buffer_read) begin
        rx_buf_full_reg <= 1'b0;
      end
      if (normal_stop) begin // R13
        rx_err_reg[uart_brk_pkg::ERR_OVERRUN] <= rx_err_reg[uart_brk_pkg::ERR_OVERRUN] | rx_ove;
        rx_err_reg[uart_brk_pkg::ERR_FRAMING] <= rx_err_reg[uart_brk_pkg::ERR_FRAMING] | rx_fe;
      end else if (rx_status_read) begin
        rx_err_reg <= 3'h0;
      end
    end
  end

  // Outputs straight from flip-flops
  assign serial_tx_pin = serial_tx_reg;
  assign break_tx_trigger = break_tx_trigger_reg;
  assign break_rx_trigger = break_rx_trigger_reg;
  assign break_rx_flag = break_rx_flag_reg;
  assign tx_busy = tx_busy_reg;
  assign tx_buffer_full = tx_buf_full_reg;
  assign rx_buffer = rx_buffer_reg;
  assign rx_error_status = rx_err_reg;
  assign tx_complete_irq = tx_complete_irq_reg;
  assign rx_complete_irq = rx_complete_irq_reg;
  assign rx_error_irq = rx_error_irq_reg;

endmodule : uart_break_baud

`default_nettype wire

// *** design/uart_brk_pkg.sv ***
// Constants, control struct and state codes for the break field and baud generator
package uart_brk_pkg;

  // Prescaler and base clock selection
  localparam int PRE_W = 10;
  localparam logic [3:0] CS_MAX_DIV = 4'hA;
  localparam logic [3:0] CS_TIMER = 4'hB;

  // Divisor limits
  localparam logic [7:0] DIV_MIN = 8'h04;

  // Frame shape
  localparam logic [3:0] RX_STOP_IDX = 4'h8;
  localparam logic [4:0] TX_FRAME_LAST = 5'h09;
  localparam logic [9:0] TX_IDLE_SHIFT = 10'h3FF;

  // Break field lengths
  localparam logic [2:0] BRK_BASE_CODE = 3'h5;
  localparam logic [4:0] BRK_BASE_BITS = 5'h0D;
  localparam logic [7:0] BRK_RX_MIN = 8'h0B;
  localparam logic [7:0] BRK_LOW_MAX = 8'hFF;

  // Receive buffer and error status layout
  localparam logic [7:0] RXB_RESET = 8'hFF;
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_FRAMING = 1;
  localparam int ERR_PARITY = 2;

  // Software control bits
  typedef struct packed {
    logic port_power_bit;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic [3:0] clock_select_field;
    logic [7:0] divisor_field;
    logic [2:0] break_length_field;
  } serial_ctrl_s;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_FRAME = 3'b010,
    TX_BREAK = 3'b100
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } rx_state_e;

endpackage : uart_brk_pkg

// *** test/remote_node.sv ***
// Remote serial node model driving the receive pin and decoding the transmit pin
`timescale 1ns/1ps
`default_nettype none
module remote_node (
  // Clock
  input wire logic clk_sys,
  // Pins
  input wire logic serial_tx_pin,
  output logic serial_rx_pin
);
  // Line idles high
  initial serial_rx_pin = 1'b1;
  // Send bits LSB first, bit_cyc clocks each, then release high
  task automatic send(input logic [19:0] val, input int nbits, input int bit_cyc);
    for (int i = 0; i < nbits; i++) begin
      serial_rx_pin = val[i];
      repeat (bit_cyc) @(negedge clk_sys);
    end
    serial_rx_pin = 1'b1;
  endtask : send
  // Count clocks of the next low stretch on the transmit pin
  task automatic low_len(output int n);
    int w;
    n = 0;
    w = 0;
    while (serial_tx_pin === 1'b1 && w < 20000) begin
      @(negedge clk_sys);
      w++;
    end
    while (serial_tx_pin === 1'b0 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : low_len
  // Decode one frame, sampling each bit in its middle
  task automatic recv(input int bit_cyc, output logic [7:0] d);
    int w;
    w = 0;
    while (serial_tx_pin !== 1'b0 && w < 20000) begin
      @(negedge clk_sys);
      w++;
    end
    repeat (bit_cyc / 2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(negedge clk_sys);
      d[i] = serial_tx_pin;
    end
    repeat (bit_cyc) @(negedge clk_sys);
  endtask : recv
endmodule : remote_node
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the break field and baud generator block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys, rst_b, break_tx_set, break_rx_set, tx_write, rx_buffer_read, rx_status_read;
  logic serial_rx_pin, timer_output_pin, serial_tx_pin, break_tx_trigger, break_rx_trigger;
  logic break_rx_flag, tx_busy, tx_buffer_full, tx_complete_irq, rx_complete_irq, rx_error_irq;
  logic [7:0] tx_data, rx_buffer, d0, d1, g0, g1;
  logic [2:0] rx_error_status;
  uart_brk_pkg::serial_ctrl_s ctrl;
  int failures, num_checks, base, len, bc;
  int tx_irqs = 0;
  int rx_irqs = 0;
  int err_irqs = 0;
  uart_break_baud uart_break_baud_i (.clk_sys, .rst_b, .ctrl, .break_tx_set, .break_rx_set,
    .tx_write, .tx_data, .rx_buffer_read, .rx_status_read, .serial_rx_pin, .timer_output_pin,
    .serial_tx_pin, .break_tx_trigger, .break_rx_trigger, .break_rx_flag, .tx_busy,
    .tx_buffer_full, .rx_buffer, .rx_error_status, .tx_complete_irq, .rx_complete_irq,
    .rx_error_irq);
  remote_node remote_node_i (.clk_sys, .serial_tx_pin, .serial_rx_pin);
  // Clock and timer output with 50 percent duty
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    timer_output_pin = 1'b0;
    forever begin
      repeat (2) @(negedge clk_sys);
      timer_output_pin = ~timer_output_pin;
    end
  end
  // Interrupt pulse counters
  always @(posedge clk_sys) begin
    if (tx_complete_irq === 1'b1) tx_irqs++;
    if (rx_complete_irq === 1'b1) rx_irqs++;
    if (rx_error_irq === 1'b1) err_irqs++;
  end
  function automatic int brk_bits(input logic [2:0] code);
    return 13 + ((int'(code) + 3) % 8);
  endfunction : brk_bits
  function automatic int bit_cyc(input logic [3:0] cs, input logic [7:0] k);
    return 2 * int'(k) * ((cs == uart_brk_pkg::CS_TIMER) ? 4 : (1 << cs));
  endfunction : bit_cyc
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse
  task automatic wait_cnt(input int lim, input int was, input logic rx);
    int n;
    n = 0;
    while ((rx ? rx_irqs : tx_irqs) == was && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      failures++;
      end_of_test();
    end
  endtask : wait_cnt
  // Main sequence
  initial begin
    void'($urandom(77));
    failures = 0;
    num_checks = 0;
    ctrl = '0;
    ctrl.port_power_bit = 1'b1;
    ctrl.tx_enable_bit = 1'b1;
    ctrl.divisor_field = 8'h04;
    {break_tx_set, break_rx_set, tx_write, rx_buffer_read, rx_status_read} = 5'h00;
    tx_data = 8'h00;
    rst_b = 1'b0;
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    check(serial_tx_pin === 1'b1 && rx_buffer === uart_brk_pkg::RXB_RESET, "reset");
    pulse(break_rx_set);
    check(break_rx_trigger === 1'b0, "arm refused");
    ctrl.rx_enable_bit = 1'b1;
    for (int c = 0; c < 8; c++) begin
      ctrl.break_length_field = 3'(c);
      base = tx_irqs;
      pulse(break_tx_set);
      remote_node_i.low_len(len);
      check(len == brk_bits(3'(c)) * 8, "break length");
      wait_cnt(50, base, 1'b0);
      check(break_tx_trigger === 1'b0 && tx_irqs == base + 1, "break end");
    end
    repeat (40) @(negedge clk_sys);
    check(tx_busy === 1'b0 && serial_tx_pin === 1'b1, "idle after break");
    for (int i = 0; i < 3; i++) begin
      ctrl.divisor_field = (i == 0) ? 8'hFF : 8'($urandom_range(4, 9));
      ctrl.clock_select_field = 4'(i == 2);
      bc = bit_cyc(ctrl.clock_select_field, ctrl.divisor_field);
      base = tx_irqs;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      tx_data = d0;
      pulse(tx_write);
      @(negedge clk_sys);
      tx_data = d1;
      pulse(tx_write);
      remote_node_i.recv(bc, g0);
      remote_node_i.recv(bc, g1);
      check(g0 === d0 && g1 === d1, "tx bytes");
      wait_cnt(2000, base + 1, 1'b0);
      check(tx_irqs == base + 2, "tx irq count");
    end
    ctrl.divisor_field = 8'h04;
    ctrl.clock_select_field = 4'h0;
    pulse(rx_buffer_read);
    pulse(rx_status_read);
    d0 = 8'($urandom);
    base = rx_irqs;
    remote_node_i.send({10'h000, 1'b1, d0, 1'b0}, 10, 8);
    wait_cnt(100, base, 1'b1);
    check(rx_buffer === d0 && rx_error_status === 3'h0, "rx byte");
    base = rx_irqs;
    for (int g = 1; g <= 3; g++) begin
      remote_node_i.send(20'h00000, 1, g);
      repeat (100) @(negedge clk_sys);
    end
    check(rx_irqs == base && rx_buffer === d0, "glitch");
    pulse(break_rx_set);
    for (int n = 10; n <= 11; n++) begin
      base = rx_irqs;
      remote_node_i.send(20'h00000, n, 8);
      repeat (40) @(negedge clk_sys);
      check(rx_irqs - base == n - 10 && break_rx_trigger === 1'(n == 10)
        && break_rx_flag === 1'(n == 10), "break rx");
    end
    check(rx_buffer === d0 && rx_error_status === 3'h0, "break rx side");
    // Normal frame with low stop while buffer still full: overrun and framing
    base = rx_irqs;
    remote_node_i.send({10'h000, 1'b0, d1, 1'b0}, 10, 8);
    wait_cnt(100, base, 1'b1);
    check(rx_error_status === 3'h3 && err_irqs == 1 && rx_buffer === d0, "rx errors");
    ctrl.clock_select_field = uart_brk_pkg::CS_TIMER;
    ctrl.break_length_field = uart_brk_pkg::BRK_BASE_CODE;
    bc = bit_cyc(uart_brk_pkg::CS_TIMER, 8'h04) * brk_bits(uart_brk_pkg::BRK_BASE_CODE);
    pulse(break_tx_set);
    remote_node_i.low_len(len);
    check(len >= bc - 4 && len <= bc + 4, "timer break");
    repeat (4) @(negedge clk_sys);
    ctrl.clock_select_field = 4'hC;
    pulse(break_tx_set);
    repeat (200) @(negedge clk_sys);
    check(break_tx_trigger === 1'b1 && serial_tx_pin === 1'b0, "no tick");
    ctrl.port_power_bit = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(serial_tx_pin === 1'b1 && tx_busy === 1'b0, "power off");
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule : testbench
bind uart_break_baud uart_brk_chk uart_brk_chk_i (.clk_sys, .rst_b, .ctrl, .break_tx_set,
  .tx_write, .serial_tx_pin, .break_tx_trigger, .break_rx_trigger, .break_rx_flag, .tx_busy,
  .tx_buffer_full, .rx_buffer, .rx_error_status, .tx_complete_irq, .rx_complete_irq);
`default_nettype wire

// *** test/uart_brk_chk.sv ***
// Port assertions for the break field and baud generator block
`timescale 1ns/1ps
`default_nettype none
module uart_brk_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Controls
  input wire uart_brk_pkg::serial_ctrl_s ctrl,
  input wire logic break_tx_set,
  input wire logic tx_write,
  // Pins and status
  input wire logic serial_tx_pin,
  input wire logic break_tx_trigger,
  input wire logic break_rx_trigger,
  input wire logic break_rx_flag,
  input wire logic tx_busy,
  input wire logic tx_buffer_full,
  input wire logic [7:0] rx_buffer,
  input wire logic [2:0] rx_error_status,
  input wire logic tx_complete_irq,
  input wire logic rx_complete_irq
);
  logic tx_on;
  logic rx_on;
  // Side enables
  assign tx_on = ctrl.port_power_bit && ctrl.tx_enable_bit;
  assign rx_on = ctrl.port_power_bit && ctrl.rx_enable_bit;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  idle_high_a: assert property (!tx_busy && !$past(tx_busy) |-> serial_tx_pin)
    else $error("transmit pin low while idle");
  brk_start_a: assert property (break_tx_set && tx_on && !tx_busy && !tx_buffer_full && !tx_write
    |=> ##1 tx_busy ##1 !serial_tx_pin)
    else $error("break did not start");
  brk_end_a: assert property ($fell(break_tx_trigger) && tx_on && $past(tx_on)
    |-> ##[0:1] tx_complete_irq)
    else $error("no completion after break");
  stay_idle_a: assert property (!tx_busy && !tx_buffer_full && !break_tx_trigger && !tx_write
    && !break_tx_set |=> !tx_busy)
    else $error("transmit left idle unasked");
  power_off_a: assert property (!ctrl.port_power_bit |=> serial_tx_pin && !tx_busy)
    else $error("activity with power off");
  rx_done_a: assert property (rx_complete_irq && $past(break_rx_flag, 2)
    |-> ##[0:1] (!break_rx_flag && !break_rx_trigger))
    else $error("break receive bits not cleared");
  flag_irq_a: assert property ($fell(break_rx_flag) && rx_on && $past(rx_on)
    |-> ##[0:1] rx_complete_irq)
    else $error("break flag cleared without interrupt");
  err_quiet_a: assert property (break_rx_flag
    |=> (rx_error_status & ~$past(rx_error_status)) == 3'h0)
    else $error("error flag set in break reception");
  buf_keep_a: assert property (break_rx_flag |=> $stable(rx_buffer))
    else $error("receive buffer written in break reception");
  brk_tx_c: cover property ($fell(break_tx_trigger));
  brk_rx_c: cover property (rx_complete_irq && $past(break_rx_flag, 2));
  rx_byte_c: cover property (rx_complete_irq && !$past(break_rx_flag, 2));
endmodule : uart_brk_chk
`default_nettype wire
